// >>> verilog/ccp_ctrl_pins.sv
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/10ps

// Function
// - Source pin low crystal, high external
// - Source pin sense invertible by programming
// - Function bit high means shutdown, else enable
// - Polarity bit only affects enable function
// - Enable pin active low by default
// - Shutdown: differential static, single-ended low
// - Disabled outputs tri-state or static, programmable
// - Serial bit turns select pins into bus
module ccp_ctrl_pins (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Control pins.
    input wire logic input_source_select,
    input wire logic shutdown_or_output_enable_pin,
    input wire logic config_select1_or_serial_data,
    input wire logic config_select0_or_serial_clock,
    // Effects on the clock path.
    output logic use_external_clock_input,
    output logic power_down,
    output logic [1:0] config_sel,
    output logic serial_sda_in,
    output logic serial_scl_in,
    output logic diff_out_oe,
    output logic diff_out_static,
    output logic diff_out_level,
    output logic se_out_oe,
    output logic se_out_static
);

    ccp_pkg::ccp_ctrl_s ctrl_ff;
    ccp_pkg::ccp_pin_state_s pin_state;
    logic [31:0] nxt_prdata;
    logic wr_ctrl;
    logic addr_ok;

    // ==========================================================
    // APB slave: zero wait states, error on unmapped address.
    assign addr_ok = (paddr == ccp_pkg::CTRL_OFFSET) || (paddr == ccp_pkg::STAT_OFFSET);
    assign pready = 1'h1;
    assign pslverr = psel & penable & ~addr_ok;
    assign wr_ctrl = psel & penable & pwrite & (paddr == ccp_pkg::CTRL_OFFSET);

    // Control register written by software.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= ccp_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_ff <= pwdata[ccp_pkg::CTRL_WIDTH-1:0];
        end
    end

    // Read mux: control readback or live decoded state.
    always_comb begin
        nxt_prdata = 32'h0;
        if (paddr == ccp_pkg::CTRL_OFFSET) begin
            nxt_prdata[ccp_pkg::CTRL_WIDTH-1:0] = ctrl_ff;
        end else if (paddr == ccp_pkg::STAT_OFFSET) begin
            nxt_prdata[7:0] = pin_state;
        end
    end

    // Read data register, loaded in the setup cycle of a read.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel & ~penable & ~pwrite) begin
            prdata <= nxt_prdata;
        end
    end

    // ==========================================================
    // Pin decode.
    ccp_pin_decode i_ccp_pin_decode (
        .ctrl(ctrl_ff),
        .input_source_select(input_source_select),
        .shutdown_or_output_enable_pin(shutdown_or_output_enable_pin),
        .config_select1_or_serial_data(config_select1_or_serial_data),
        .config_select0_or_serial_clock(config_select0_or_serial_clock),
        .state(pin_state)
    );

    // ==========================================================
    // Registered output controls.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            use_external_clock_input <= 1'h0;
            power_down <= 1'h0;
            config_sel <= 2'h0;
            serial_sda_in <= 1'h1;
            serial_scl_in <= 1'h1;
        end else begin
            use_external_clock_input <= pin_state.use_external;
            power_down <= pin_state.shutdown;
            config_sel <= pin_state.config_sel;
            serial_sda_in <= pin_state.serial_sda;
            serial_scl_in <= pin_state.serial_scl;
        end
    end

    // Output drivers: shutdown forces static, disable follows tri-state bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            diff_out_oe <= 1'h1;
            diff_out_static <= 1'h0;
            diff_out_level <= 1'h0;
            se_out_oe <= 1'h1;
            se_out_static <= 1'h0;
        end else if (pin_state.shutdown) begin
            diff_out_oe <= 1'h1;
            diff_out_static <= 1'h1;
            diff_out_level <= 1'h0;
            se_out_oe <= 1'h1;
            se_out_static <= 1'h1;
        end else if (pin_state.outputs_off) begin
            diff_out_oe <= ~pin_state.outputs_tristate;
            diff_out_static <= 1'h1;
            diff_out_level <= 1'h0;
            se_out_oe <= ~pin_state.outputs_tristate;
            se_out_static <= 1'h1;
        end else begin
            diff_out_oe <= 1'h1;
            diff_out_static <= 1'h0;
            diff_out_level <= 1'h0;
            se_out_oe <= 1'h1;
            se_out_static <= 1'h0;
        end
    end

    // ==========================================================
    // Checks.

    // Source selection follows the pin one edge later, through the inversion bit.
    a_src_follow: assert property (@(posedge pclk) disable iff (!presetn)
        use_external_clock_input == $past(input_source_select ^ ctrl_ff.source_invert))
        else $error("source select wrong");
    a_src_default: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_ff.source_invert |=> use_external_clock_input == $past(input_source_select))
        else $error("source not taken as is");
    a_src_invert: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_ff.source_invert |=> use_external_clock_input != $past(input_source_select))
        else $error("invert not applied");

    // A written control word is held from the edge after the access on.
    a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pwrite && paddr == ccp_pkg::CTRL_OFFSET)
        |=> ctrl_ff == $past(pwdata[ccp_pkg::CTRL_WIDTH-1:0]))
        else $error("control write lost");

    // Only the function bit turns the pin into a shutdown control.
    a_sd_powers: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_ff.pin_function_select_bit && shutdown_or_output_enable_pin) |=> power_down)
        else $error("shutdown missed");
    a_oe_nopd: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_ff.pin_function_select_bit |=> !power_down)
        else $error("enable mode powered down");

    // Polarity sets the enable sense and leaves the shutdown sense alone.
    a_pol_high: assert property (@(posedge pclk) disable iff (!presetn)
        (!ctrl_ff.pin_function_select_bit && ctrl_ff.pin_polarity_bit
         && !shutdown_or_output_enable_pin) |=> se_out_static)
        else $error("active high disable");
    a_en_drive: assert property (@(posedge pclk) disable iff (!presetn)
        (!ctrl_ff.pin_function_select_bit
         && shutdown_or_output_enable_pin == ctrl_ff.pin_polarity_bit)
        |=> diff_out_oe && !diff_out_static && se_out_oe && !se_out_static)
        else $error("enabled outputs not running");
    a_sd_nopol: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl_ff.pin_function_select_bit && !shutdown_or_output_enable_pin)
        |=> !power_down && se_out_oe && !se_out_static)
        else $error("polarity reached shutdown");

    // With the polarity bit clear the enable pin is active low.
    a_pol_default: assert property (@(posedge pclk) disable iff (!presetn)
        (!ctrl_ff.pin_function_select_bit && !ctrl_ff.pin_polarity_bit
         && !shutdown_or_output_enable_pin) |=> !se_out_static && se_out_oe)
        else $error("active low enable");

    // Shutdown keeps every output driven and static.
    a_sd_static: assert property (@(posedge pclk) disable iff (!presetn)
        power_down |-> (se_out_oe && se_out_static && diff_out_static && diff_out_oe))
        else $error("shutdown outputs");

    // Disabled outputs float or hold static, as the tri-state bit asks.
    a_dis_tri: assert property (@(posedge pclk) disable iff (!presetn)
        (!ctrl_ff.pin_function_select_bit && ctrl_ff.tristate_select
         && !ctrl_ff.pin_polarity_bit && shutdown_or_output_enable_pin) |=> !diff_out_oe)
        else $error("tri-state missed");
    a_dis_tri_hi: assert property (@(posedge pclk) disable iff (!presetn)
        (!ctrl_ff.pin_function_select_bit && ctrl_ff.tristate_select
         && ctrl_ff.pin_polarity_bit && !shutdown_or_output_enable_pin)
        |=> !diff_out_oe && !se_out_oe)
        else $error("active high tri-state missed");
    a_dis_static: assert property (@(posedge pclk) disable iff (!presetn)
        (!ctrl_ff.pin_function_select_bit && !ctrl_ff.tristate_select
         && shutdown_or_output_enable_pin != ctrl_ff.pin_polarity_bit)
        |=> diff_out_oe && diff_out_static && se_out_oe && se_out_static)
        else $error("static disable missed");

    // Serial mode masks the selects and hands the pins to the serial bus.
    a_serial_sel: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_ff.serial_mode_select_bit ##1 $stable(ctrl_ff) |-> config_sel == 2'h0)
        else $error("selects not masked");
    a_serial_pass: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_ff.serial_mode_select_bit
        |=> serial_sda_in == $past(config_select1_or_serial_data)
            && serial_scl_in == $past(config_select0_or_serial_clock))
        else $error("serial lines not passed");
    a_cfg_follow: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_ff.serial_mode_select_bit
        |=> config_sel == $past({config_select1_or_serial_data,
                                 config_select0_or_serial_clock})
            && serial_sda_in && serial_scl_in)
        else $error("selects not followed");

endmodule : ccp_ctrl_pins

// >>> verilog/ccp_pkg.sv
package ccp_pkg;

    // ==========================================================
    // Register map (byte offsets on the APB bus).
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STAT_OFFSET = 8'h04;

    // ==========================================================
    // Control register field positions.
    localparam int CTRL_SRC_INV_BIT = 0;
    localparam int CTRL_FUNC_BIT = 1;
    localparam int CTRL_POL_BIT = 2;
    localparam int CTRL_TRI_BIT = 3;
    localparam int CTRL_SERIAL_BIT = 4;
    localparam int CTRL_WIDTH = 5;

    // Control value after reset: all bits clear.
    localparam logic [4:0] CTRL_RESET = 5'h00;

    // ==========================================================
    // Decoded pin state handed from the pin logic to the top.
    typedef struct packed {
        logic use_external;
        logic shutdown;
        logic outputs_off;
        logic outputs_tristate;
        logic [1:0] config_sel;
        logic serial_sda;
        logic serial_scl;
    } ccp_pin_state_s;

    // Programmed control bits.
    typedef struct packed {
        logic serial_mode_select_bit;
        logic tristate_select;
        logic pin_polarity_bit;
        logic pin_function_select_bit;
        logic source_invert;
    } ccp_ctrl_s;

endpackage : ccp_pkg

// >>> verilog/ccp_pin_decode.sv
`timescale 1ns/10ps

// ==========================================================
// Combinational decode of the control pins against programmed bits.
module ccp_pin_decode (
    // Programmed control bits.
    input wire ccp_pkg::ccp_ctrl_s ctrl,
    // Pin levels.
    input wire logic input_source_select,
    input wire logic shutdown_or_output_enable_pin,
    input wire logic config_select1_or_serial_data,
    input wire logic config_select0_or_serial_clock,
    // Decoded state.
    output ccp_pkg::ccp_pin_state_s state
);

    logic pin_asserted;

    // Pin sense: shutdown is active high; output enable follows polarity.
    always_comb begin
        if (ctrl.pin_function_select_bit) begin
            pin_asserted = shutdown_or_output_enable_pin;
        end else begin
            // Polarity clear means active low: outputs run while the pin is low.
            pin_asserted = ctrl.pin_polarity_bit ? shutdown_or_output_enable_pin
                                                 : ~shutdown_or_output_enable_pin;
        end
    end

    // Decode of source, shutdown, enable and the shared select pins.
    always_comb begin
        state.use_external = input_source_select ^ ctrl.source_invert;
        state.shutdown = ctrl.pin_function_select_bit & pin_asserted;
        state.outputs_off = ~ctrl.pin_function_select_bit & ~pin_asserted;
        state.outputs_tristate = ctrl.tristate_select;
        if (ctrl.serial_mode_select_bit) begin
            state.config_sel = 2'h0;
            state.serial_sda = config_select1_or_serial_data;
            state.serial_scl = config_select0_or_serial_clock;
        end else begin
            state.config_sel = {config_select1_or_serial_data,
                                config_select0_or_serial_clock};
            state.serial_sda = 1'h1;
            state.serial_scl = 1'h1;
        end
    end

endmodule : ccp_pin_decode

// >>> dv/ccp_host_pins.sv
`timescale 1ns/10ps

// ==========================================================
// Host GPIO and strap model that drives the four control pins.
module ccp_host_pins (
    // Drive enables and levels from the bench.
    input wire logic [3:0] drv,
    input wire logic [3:0] val,
    // Pin levels seen by the device.
    output logic [3:0] pin
);
    // A released pin falls to the weak pull-down level.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin[i] = drv[i] ? val[i] : 1'h0;
        end
    end
endmodule : ccp_host_pins

// >>> dv/tb.sv
`timescale 1ns/10ps

// ==========================================================
// Self-checking bench for the control pin block.
module tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] drv, val, pin;
    logic pd, doe, dst, dlv, seoe, sest, use_ext, sda, scl;
    logic [1:0] csel;
    logic [7:0] obs, ser;
    int err_count, cmp_count;

    // Observation vectors: output state and serial pin view.
    assign obs = {pd, doe, dst, dlv, seoe, sest, use_ext, 1'h0};
    assign ser = {4'h0, csel, sda, scl};

    ccp_host_pins i_ccp_host_pins (.drv(drv), .val(val), .pin(pin));

    ccp_ctrl_pins i_ccp_ctrl_pins (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .input_source_select(pin[3]), .shutdown_or_output_enable_pin(pin[2]),
        .config_select1_or_serial_data(pin[1]), .config_select0_or_serial_clock(pin[0]),
        .use_external_clock_input(use_ext), .power_down(pd), .config_sel(csel),
        .serial_sda_in(sda), .serial_scl_in(scl), .diff_out_oe(doe),
        .diff_out_static(dst), .diff_out_level(dlv), .se_out_oe(seoe), .se_out_static(sest));

    // Clock at 100 MHz.
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Masked comparison that counts and reports.
    task chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
        cmp_count++;
        if ((got & m) !== (exp & m)) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One APB transfer, held until pready is seen high at a rising edge.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    // Control write, then let the pin outputs follow.
    task ctl(input logic [7:0] d);
        apb(1'h1, ccp_pkg::CTRL_OFFSET, {24'h0, d});
        repeat (3) @(posedge pclk);
        #1;
    endtask : ctl

    // Drive all four pins and let the outputs follow.
    task setpins(input logic [3:0] v);
        @(posedge pclk);
        drv <= 4'hf;
        val <= v;
        repeat (3) @(posedge pclk);
        #1;
    endtask : setpins

    // Release all four pins so that the pull-downs set their level.
    task relpins;
        @(posedge pclk);
        drv <= 4'h0;
        repeat (3) @(posedge pclk);
        #1;
    endtask : relpins

    // Source pin sense, its inversion and the released pin level.
    task t_source;
        ctl(8'h00);
        setpins(4'h0);
        chk(obs, 8'h00, 8'h02);
        setpins(4'h8);
        chk(obs, 8'h02, 8'h02);
        ctl(8'h01);
        chk(obs, 8'h00, 8'h02);
        setpins(4'h0);
        chk(obs, 8'h02, 8'h02);
        setpins(4'h8);
        relpins();
        chk(obs, 8'h02, 8'h02);
    endtask : t_source

    // Output enable function, polarity and disabled states.
    task t_enable;
        ctl(8'h00);
        setpins(4'h0);
        chk(obs, 8'h48, 8'hfc);
        setpins(4'h4);
        chk(obs, 8'h6c, 8'hfc);
        ctl(8'h08);
        chk(obs, 8'h24, 8'hfc);
        setpins(4'h0);
        chk(obs, 8'h48, 8'hfc);
        ctl(8'h04);
        setpins(4'h4);
        chk(obs, 8'h48, 8'hfc);
        setpins(4'h0);
        chk(obs, 8'h6c, 8'hfc);
        ctl(8'h0c);
        chk(obs, 8'h24, 8'hfc);
    endtask : t_enable

    // Shutdown function, with polarity and tri-state bits ignored.
    task t_shutdown;
        ctl(8'h02);
        setpins(4'h0);
        chk(obs, 8'h48, 8'hfc);
        setpins(4'h4);
        chk(obs, 8'hec, 8'hfc);
        ctl(8'h06);
        chk(obs, 8'hec, 8'hfc);
        ctl(8'h0e);
        chk(obs, 8'hec, 8'hfc);
        setpins(4'h0);
        chk(obs, 8'h48, 8'hfc);
    endtask : t_shutdown

    // Select pins as configuration inputs, then as serial lines.
    task t_serial;
        ctl(8'h00);
        setpins(4'h6);
        chk(ser, 8'h0b, 8'hff);
        setpins(4'h5);
        chk(ser, 8'h07, 8'hff);
        ctl(8'h10);
        setpins(4'h6);
        chk(ser, 8'h02, 8'hff);
        setpins(4'h5);
        chk(ser, 8'h01, 8'hff);
    endtask : t_serial

    // Register readback, status view, read-only status and an unmapped address.
    task t_regs;
        apb(1'h1, ccp_pkg::CTRL_OFFSET, 32'hffff_ffff);
        apb(1'h0, ccp_pkg::CTRL_OFFSET, 32'h0);
        chk(rd[7:0], 8'h1f, 8'hff);
        chk(rd[31:24], 8'h00, 8'hff);
        chk({7'h0, er}, 8'h00, 8'hff);
        chk(obs, 8'hee, 8'hfe);
        apb(1'h0, ccp_pkg::STAT_OFFSET, 32'h0);
        chk(rd[7:0], 8'hd1, 8'hff);
        apb(1'h1, ccp_pkg::STAT_OFFSET, 32'h0);
        apb(1'h1, 8'h08, 32'h0);
        chk({7'h0, er}, 8'h01, 8'hff);
        apb(1'h0, 8'h08, 32'h0);
        chk({7'h0, er}, 8'h01, 8'hff);
        chk(rd[7:0], 8'h00, 8'hff);
        apb(1'h0, ccp_pkg::CTRL_OFFSET, 32'h0);
        chk(rd[7:0], 8'h1f, 8'hff);
    endtask : t_regs

    // Reset in mid-run brings back the default control bits and outputs.
    task t_reset;
        setpins(4'h0);
        @(posedge pclk);
        presetn <= 1'h0;
        repeat (3) @(posedge pclk);
        chk(obs, 8'h48, 8'hfe);
        presetn <= 1'h1;
        apb(1'h0, ccp_pkg::CTRL_OFFSET, 32'h0);
        chk(rd[7:0], 8'h00, 8'hff);
        chk(obs, 8'h48, 8'hfe);
    endtask : t_reset

    // Print counts and verdict, then stop.
    task give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    // Watchdog against a hang.
    initial begin
        #200us;
        err_count++;
        give_verdict();
    end

    // Main sequence.
    initial begin
        presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; drv = 4'h0; val = 4'h0;
        err_count = 0; cmp_count = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'h0, ccp_pkg::CTRL_OFFSET, 32'h0);
        chk(rd[7:0], 8'h00, 8'hff);
        t_source();
        t_enable();
        t_shutdown();
        t_serial();
        t_regs();
        t_reset();
        give_verdict();
    end
endmodule : tb
